// ---- coord_calc_pkg.sv ----
// Constants for the coordinate store and X-register calculator.
// Assumes byte-wide command frames and 32-bit signed values.
package coord_calc_pkg;
    localparam logic [7:0] GET_COORDINATE_CMD = 8'h1F;
    localparam logic [7:0] CAPTURE_COORDINATE_CMD = 8'h20;
    localparam logic [7:0] XREG_CALCULATE_CMD = 8'h21;
    localparam logic [7:0] ACCU_TO_COORDINATE_CMD = 8'h27;
    localparam logic [7:0] BANK_NVM = 8'hFF;
    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_BAD_CHECKSUM = 8'h01;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
    localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
    localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
    localparam logic [7:0] PERSIST_PARAM = 8'h54;
    localparam int FRAME_BYTES = 9;
    localparam int COORD_LAST = 20;
    localparam logic [3:0] OP_ADD = 4'h0;
    localparam logic [3:0] OP_SUB = 4'h1;
    localparam logic [3:0] OP_MUL = 4'h2;
    localparam logic [3:0] OP_DIV = 4'h3;
    localparam logic [3:0] OP_MOD = 4'h4;
    localparam logic [3:0] OP_AND = 4'h5;
    localparam logic [3:0] OP_OR = 4'h6;
    localparam logic [3:0] OP_XOR = 4'h7;
    localparam logic [3:0] OP_NOT = 4'h8;
    localparam logic [3:0] OP_LOAD = 4'h9;
    localparam logic [3:0] OP_SWAP = 4'hA;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_RESTORE = 2'b10,
        ST_REPLY = 2'b11
    } phase_e;
endpackage

// ---- frame_rx.sv ----
// Collects nine command bytes into one frame and checks its checksum.
// Assumes one byte per valid strobe, synchronous to ref_clk_i.
`timescale 1ns/1ns
module frame_rx
    import coord_calc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic busy_i,
    output logic frame_valid_o,
    output logic frame_good_o,
    output logic [63:0] frame_o
);
    typedef struct packed {
        logic [3:0] count;
        logic [7:0] sum;
        logic [63:0] data;
        logic valid;
        logic good;
    } rx_s;
    rx_s state;
    rx_s next_state;

    always_comb begin
        next_state = state;
        next_state.valid = 1'b0;
        // Bytes arriving during execution are dropped, not queued
        if (byte_valid_i && !busy_i && !state.valid) begin
            if (state.count == 4'(FRAME_BYTES - 1)) begin
                next_state.count = 4'h0;
                next_state.sum = 8'h00;
                next_state.valid = 1'b1;
                next_state.good = (state.sum == byte_i); // R16
            end else begin
                next_state.count = state.count + 4'h1;
                next_state.sum = state.sum + byte_i; // R16
                next_state.data = {state.data[55:0], byte_i}; // R15
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign frame_valid_o = state.valid;
    assign frame_good_o = state.good;
    assign frame_o = state.data;
endmodule

// ---- xreg_alu.sv ----
// Combinational accumulator/X-register operations.
// Division by zero yields zero for both quotient and remainder.
`timescale 1ns/1ns
module xreg_alu
    import coord_calc_pkg::*;
(
    input wire logic [3:0] op_i,
    input wire logic signed [31:0] accu_i,
    input wire logic signed [31:0] xreg_i,
    output logic signed [31:0] accu_o,
    output logic signed [31:0] xreg_o
);
    logic signed [63:0] product;
    assign product = accu_i * xreg_i;

    always_comb begin
        accu_o = accu_i;
        xreg_o = xreg_i;
        unique case (op_i)
            OP_ADD: accu_o = accu_i + xreg_i; // R11
            OP_SUB: accu_o = accu_i - xreg_i; // R11
            OP_MUL: accu_o = product[31:0]; // R11
            OP_DIV: accu_o = (xreg_i == 0) ? 32'sh0 : accu_i / xreg_i; // R11
            OP_MOD: accu_o = (xreg_i == 0) ? 32'sh0 : accu_i % xreg_i; // R11
            OP_AND: accu_o = accu_i & xreg_i; // R12
            OP_OR: accu_o = accu_i | xreg_i; // R12
            OP_XOR: accu_o = accu_i ^ xreg_i; // R12
            OP_NOT: xreg_o = ~xreg_i; // R12
            OP_LOAD: xreg_o = accu_i; // R13
            OP_SWAP: begin // R13
                accu_o = xreg_i;
                xreg_o = accu_i;
            end
            default: begin
                accu_o = accu_i;
                xreg_o = xreg_i;
            end
        endcase
    end
endmodule

// ---- coord_calc.sv ----
// Coordinate store and X-register calculator of a motion command interpreter.
// Assumes host frames on a byte strobe and program commands as a decoded word.
// How it works
// R1 - Get-coordinate reads entry by type and motor
// R2 - Program get-coordinate loads the accumulator
// R3 - Host get-coordinate replies value, accumulator kept
// R4 - Persistence flag selects RAM only or nonvolatile
// R5 - Entry zero never saved nor restored
// R6 - Type 0 bank 255 restores entries 1..20
// R7 - Bank 255 type n restores entry n
// R8 - Capture copies actual position into entry
// R9 - Accumulator-to-coordinate writes accumulator into entry
// R10 - Calculate uses accumulator and X, result accumulator
// R11 - Types 0-4: add, sub, mul, div, mod
// R12 - Types 5-7 logic ops, 8 inverts X
// R13 - Type 9 loads X, 10 swaps
// R14 - Host replies status 100, value for reads
// R15 - Frame: address, cmd, type, bank, value, checksum
// R16 - Checksum is byte sum of eight bytes
`timescale 1ns/1ns
module coord_calc
    import coord_calc_pkg::*;
#(
    parameter int MOTORS = 1,
    parameter logic [7:0] MODULE_ADDR = 8'h01
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic prog_valid_i,
    input wire logic [7:0] prog_cmd_i,
    input wire logic [7:0] prog_type_i,
    input wire logic [7:0] prog_bank_i,
    input wire logic persist_i,
    input wire logic signed [31:0] actual_pos_i,
    input wire logic nvm_ack_i,
    input wire logic signed [31:0] nvm_rdata_i,
    output logic nvm_req_o,
    output logic nvm_we_o,
    output logic [4:0] nvm_addr_o,
    output logic signed [31:0] nvm_wdata_o,
    output logic [7:0] motor_sel_o,
    output logic signed [31:0] accu_o,
    output logic signed [31:0] xreg_o,
    output logic busy_o,
    output logic reply_valid_o,
    output logic [7:0] reply_status_o,
    output logic [7:0] reply_cmd_o,
    output logic signed [31:0] reply_value_o
);
    localparam int ENTRIES = MOTORS * (COORD_LAST + 1);

    if (MOTORS < 1 || MOTORS > 8) begin : g_motors_check
        $error("MOTORS must be 1 to 8");
    end

    function automatic int entry_index(input logic [7:0] motor, input logic [4:0] coord);
        entry_index = int'(motor) * (COORD_LAST + 1) + int'(coord);
    endfunction

    typedef struct packed {
        phase_e phase;
        logic booted;
        logic from_host;
        logic [7:0] cmd;
        logic [7:0] ctype;
        logic [7:0] bank;
        logic [4:0] restore_idx;
        logic restore_all;
        logic nvm_req;
        logic nvm_we;
        logic [4:0] nvm_addr;
        logic signed [31:0] nvm_wdata;
        logic signed [31:0] accu;
        logic signed [31:0] xreg;
        logic reply_valid;
        logic [7:0] reply_status;
        logic signed [31:0] reply_value;
    } ctl_s;
    ctl_s state;
    ctl_s next_state;

    logic signed [31:0] coords [ENTRIES] = '{default: 32'sh0};
    logic frame_valid;
    logic frame_good;
    logic [63:0] frame;
    logic signed [31:0] alu_accu;
    logic signed [31:0] alu_xreg;
    logic coord_we;
    int coord_wsel;
    logic signed [31:0] coord_wdata;
    int rd_sel;
    logic type_ok;
    logic motor_ok;

    frame_rx u_rx (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .byte_valid_i(byte_valid_i),
        .byte_i(byte_i),
        .busy_i(busy_o),
        .frame_valid_o(frame_valid),
        .frame_good_o(frame_good),
        .frame_o(frame)
    );

    xreg_alu u_alu (
        .op_i(state.ctype[3:0]),
        .accu_i(state.accu),
        .xreg_i(state.xreg),
        .accu_o(alu_accu),
        .xreg_o(alu_xreg)
    );

    assign type_ok = state.ctype <= 8'(COORD_LAST);
    assign motor_ok = int'(state.bank) < MOTORS;
    assign rd_sel = entry_index(motor_ok ? state.bank : 8'h00, state.ctype[4:0]);

    always_comb begin
        next_state = state;
        next_state.reply_valid = 1'b0;
        next_state.nvm_req = 1'b0;
        coord_we = 1'b0;
        coord_wsel = 0;
        coord_wdata = state.accu;
        unique case (state.phase)
            ST_IDLE: begin
                next_state.booted = 1'b1;
                // Startup reload first; host frames then win over program commands
                if (!state.booted && persist_i) begin // R4
                    next_state.from_host = 1'b0;
                    next_state.restore_all = 1'b1;
                    next_state.restore_idx = 5'h01; // R5 R6
                    next_state.phase = ST_RESTORE;
                end else if (frame_valid && frame[63:56] == MODULE_ADDR) begin // R15
                    next_state.from_host = 1'b1;
                    next_state.cmd = frame[55:48];
                    next_state.ctype = frame[47:40];
                    next_state.bank = frame[39:32];
                    next_state.phase = frame_good ? ST_EXEC : ST_REPLY; // R16
                    next_state.reply_status = STATUS_BAD_CHECKSUM;
                    next_state.reply_value = 32'sh0;
                end else if (prog_valid_i) begin
                    next_state.from_host = 1'b0;
                    next_state.cmd = prog_cmd_i;
                    next_state.ctype = prog_type_i;
                    next_state.bank = prog_bank_i;
                    next_state.phase = ST_EXEC;
                end
            end
            ST_EXEC: begin
                next_state.phase = ST_REPLY;
                next_state.reply_status = STATUS_OK; // R14
                next_state.reply_value = 32'sh0;
                if (state.cmd == XREG_CALCULATE_CMD) begin
                    if (state.ctype <= 8'(OP_SWAP)) begin
                        next_state.accu = alu_accu; // R10
                        next_state.xreg = alu_xreg;
                    end else begin
                        next_state.reply_status = STATUS_BAD_TYPE;
                    end
                end else if (state.cmd == GET_COORDINATE_CMD && state.bank == BANK_NVM) begin
                    // Restore one entry or all but entry zero
                    if (!type_ok) begin
                        next_state.reply_status = STATUS_BAD_TYPE; // R7
                    end else begin
                        next_state.restore_all = (state.ctype == 8'h00); // R6
                        next_state.restore_idx = (state.ctype == 8'h00) ? 5'h01
                            : state.ctype[4:0]; // R5 R7
                        next_state.phase = ST_RESTORE;
                    end
                end else if (!type_ok || !motor_ok) begin
                    next_state.reply_status = STATUS_BAD_VALUE;
                end else if (state.cmd == GET_COORDINATE_CMD) begin // R1
                    if (state.from_host) begin
                        next_state.reply_value = coords[rd_sel]; // R3
                    end else begin
                        next_state.accu = coords[rd_sel]; // R2
                    end
                end else if (state.cmd == CAPTURE_COORDINATE_CMD
                             || state.cmd == ACCU_TO_COORDINATE_CMD) begin
                    coord_we = 1'b1;
                    coord_wsel = rd_sel;
                    coord_wdata = (state.cmd == CAPTURE_COORDINATE_CMD)
                        ? actual_pos_i : state.accu; // R8 R9
                    // Mirror to nonvolatile store only when persistence is on
                    if (persist_i && state.ctype != 8'h00) begin // R4 R5
                        next_state.nvm_req = 1'b1;
                        next_state.nvm_we = 1'b1;
                        next_state.nvm_addr = state.ctype[4:0];
                        next_state.nvm_wdata = coord_wdata;
                    end
                end else begin
                    next_state.reply_status = STATUS_BAD_CMD;
                end
            end
            ST_RESTORE: begin
                next_state.nvm_req = 1'b1;
                next_state.nvm_we = 1'b0;
                next_state.nvm_addr = state.restore_idx;
                if (state.nvm_req && nvm_ack_i) begin
                    next_state.nvm_req = 1'b0;
                    coord_we = 1'b1;
                    coord_wsel = entry_index(8'h00, state.restore_idx);
                    coord_wdata = nvm_rdata_i;
                    if (state.restore_all && state.restore_idx != 5'(COORD_LAST)) begin // R6
                        next_state.restore_idx = state.restore_idx + 5'h01;
                    end else begin
                        next_state.phase = ST_REPLY;
                    end
                end
            end
            ST_REPLY: begin
                next_state.phase = ST_IDLE;
                next_state.reply_valid = state.from_host; // R14
            end
            default: next_state.phase = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Array kept out of reset so it can map to RAM; entries start at zero
    always_ff @(posedge ref_clk_i) begin
        if (coord_we) begin
            coords[coord_wsel] <= coord_wdata;
        end
    end

    assign nvm_req_o = state.nvm_req;
    assign nvm_we_o = state.nvm_we;
    assign nvm_addr_o = state.nvm_addr;
    assign nvm_wdata_o = state.nvm_wdata;
    assign motor_sel_o = state.bank;
    assign accu_o = state.accu;
    assign xreg_o = state.xreg;
    // Startup reload counts as busy so no strobe is lost to it
    assign busy_o = state.phase != ST_IDLE || frame_valid || (!state.booted && persist_i);
    assign reply_valid_o = state.reply_valid;
    assign reply_status_o = state.reply_status;
    assign reply_cmd_o = state.cmd;
    assign reply_value_o = state.reply_value;

    a_host_get_keeps_accu: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R3
        state.phase == ST_EXEC && state.from_host && state.cmd == GET_COORDINATE_CMD
        |=> $stable(state.accu)) else $error("Host read changed accumulator");
    a_reply_after_exec: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R14
        state.phase == ST_EXEC && state.from_host && state.bank != BANK_NVM
        |=> ##1 reply_valid_o) else $error("Reply missing");
    a_ok_status: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R10
        state.phase == ST_EXEC && state.cmd == XREG_CALCULATE_CMD && state.ctype == 8'h00
        |=> state.reply_status == STATUS_OK && state.accu == $past(state.accu)
        + $past(state.xreg)) else $error("Add result wrong");
    a_load_copies: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R13
        state.phase == ST_EXEC && state.cmd == XREG_CALCULATE_CMD && state.ctype == 8'h09
        |=> state.xreg == $past(state.accu)) else $error("Load wrong");
    a_no_save_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R5
        nvm_req_o |-> nvm_addr_o != 5'h00) else $error("Entry zero touched nonvolatile");
    a_save_only_persist: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R4
        $rose(nvm_req_o) && nvm_we_o |-> $past(persist_i)) else $error("Save without flag");
    a_not_inverts: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R12
        state.phase == ST_EXEC && state.cmd == XREG_CALCULATE_CMD && state.ctype == 8'h08
        |=> state.xreg == ~$past(state.xreg) && $stable(state.accu))
        else $error("Invert wrong");
    a_prog_no_reply: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R2
        state.phase == ST_REPLY && !state.from_host |=> !reply_valid_o)
        else $error("Program command replied");
    a_boot_reload: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R4
        !state.booted && persist_i |=> state.phase == ST_RESTORE && state.restore_all
        && state.restore_idx == 5'h01) else $error("Startup reload missing");
    a_restore_step: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R6
        state.phase == ST_RESTORE && state.nvm_req && nvm_ack_i && state.restore_all
        && state.restore_idx != 5'(COORD_LAST) |=> state.phase == ST_RESTORE
        && state.restore_idx == $past(state.restore_idx) + 5'h01)
        else $error("Restore step wrong");
    a_restore_single: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R7
        state.phase == ST_RESTORE && state.nvm_req && nvm_ack_i && !state.restore_all
        |=> state.phase == ST_REPLY) else $error("Single restore did not end");
    a_prog_get_loads: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R2
        state.phase == ST_EXEC && !state.from_host && state.cmd == GET_COORDINATE_CMD
        && state.bank != BANK_NVM && type_ok && motor_ok
        |=> state.accu == $past(coords[rd_sel])) else $error("Program read lost");
    a_host_get_value: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R1
        state.phase == ST_EXEC && state.from_host && state.cmd == GET_COORDINATE_CMD
        && state.bank != BANK_NVM && type_ok && motor_ok
        |=> reply_value_o == $past(coords[rd_sel])) else $error("Read value wrong");
    a_capture_stores: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R8
        state.phase == ST_EXEC && state.cmd == CAPTURE_COORDINATE_CMD && type_ok && motor_ok
        |=> coords[$past(rd_sel)] == $past(actual_pos_i)) else $error("Capture not stored");
    a_sub_result: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R11
        state.phase == ST_EXEC && state.cmd == XREG_CALCULATE_CMD && state.ctype == 8'h01
        |=> state.accu == $past(state.accu) - $past(state.xreg)) else $error("Subtract wrong");
    a_swap_exchanges: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // R13
        state.phase == ST_EXEC && state.cmd == XREG_CALCULATE_CMD && state.ctype == 8'h0A
        |=> state.accu == $past(state.xreg) && state.xreg == $past(state.accu))
        else $error("Swap wrong");
endmodule

// ---- nvm_model.sv ----
// Nonvolatile coordinate store that answers the block's request port.
// Assumes requests change just after a clock edge; reads are acked after a random wait.
`timescale 1ns/1ns
module nvm_model (
    input wire logic ref_clk_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [4:0] addr_i,
    input wire logic signed [31:0] wdata_i,
    output logic ack_o,
    output logic signed [31:0] rdata_o,
    output int writes_o,
    output int faults_o
);
    logic signed [31:0] mem [0:31];
    int wait_n;

    initial begin
        for (int i = 0; i < 32; i++) begin
            mem[i] = 32'h0F000000 + i * 3;
        end
        ack_o = 1'b0;
        rdata_o = 32'h0;
        writes_o = 0;
        faults_o = 0;
        wait_n = -1;
    end

    always @(posedge ref_clk_i) begin
        ack_o <= 1'b0;
        // Stale read data keeps toggling so it never passes for a fresh value
        rdata_o <= ~rdata_o;
        if (req_i && !ack_o) begin
            if (addr_i == 5'h0 || addr_i > 5'h14) begin
                faults_o <= faults_o + 1;
            end
            if (we_i) begin
                mem[addr_i] <= wdata_i;
                writes_o <= writes_o + 1;
                ack_o <= 1'b1;
            end else if (wait_n < 0) begin
                wait_n = $urandom_range(0, 3);
            end else if (wait_n == 0) begin
                rdata_o <= mem[addr_i];
                ack_o <= 1'b1;
                wait_n = -1;
            end else begin
                wait_n = wait_n - 1;
            end
        end
    end
endmodule

// ---- coord_calc_test.sv ----
// Self-checking bench for the coordinate store and X-register calculator.
// Assumes the nonvolatile model on the far side; host bytes and program words driven here.
`timescale 1ns/1ns
module coord_calc_test import coord_calc_pkg::*;;
    typedef struct {
        logic [7:0] st;
        logic [7:0] cmd;
        logic care;
        logic signed [31:0] val;
        logic signed [31:0] acc;
        logic signed [31:0] xr;
    } note_s;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic byte_valid_i = 1'b0;
    logic [7:0] byte_i = 8'h00;
    logic prog_valid_i = 1'b0;
    logic [7:0] prog_cmd_i = 8'h00;
    logic [7:0] prog_type_i = 8'h00;
    logic [7:0] prog_bank_i = 8'h00;
    logic persist_i = 1'b0;
    logic signed [31:0] actual_pos_i = 32'h0;
    logic nvm_ack_i, nvm_req_o, nvm_we_o, busy_o, reply_valid_o;
    logic signed [31:0] nvm_rdata_i, nvm_wdata_o, accu_o, xreg_o, reply_value_o;
    logic [4:0] nvm_addr_o;
    logic [7:0] motor_sel_o, reply_status_o, reply_cmd_o;
    int writes, faults, wexp, errors, compares;
    logic signed [31:0] acc, xr;
    logic signed [31:0] ram [0:20];
    logic signed [31:0] rom [0:20];
    note_s rq[$];
    note_s pq[$];
    logic [2:0] pv = 3'h0;

    always #25 ref_clk_i = ~ref_clk_i;

    coord_calc #(.MOTORS(1), .MODULE_ADDR(8'h01)) u_coord_calc (.ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i), .byte_valid_i(byte_valid_i), .byte_i(byte_i),
        .prog_valid_i(prog_valid_i), .prog_cmd_i(prog_cmd_i), .prog_type_i(prog_type_i),
        .prog_bank_i(prog_bank_i), .persist_i(persist_i), .actual_pos_i(actual_pos_i),
        .nvm_ack_i(nvm_ack_i), .nvm_rdata_i(nvm_rdata_i), .nvm_req_o(nvm_req_o),
        .nvm_we_o(nvm_we_o), .nvm_addr_o(nvm_addr_o), .nvm_wdata_o(nvm_wdata_o),
        .motor_sel_o(motor_sel_o), .accu_o(accu_o), .xreg_o(xreg_o), .busy_o(busy_o),
        .reply_valid_o(reply_valid_o), .reply_status_o(reply_status_o),
        .reply_cmd_o(reply_cmd_o), .reply_value_o(reply_value_o));

    nvm_model u_nvm_model (.ref_clk_i(ref_clk_i), .req_i(nvm_req_o), .we_i(nvm_we_o),
        .addr_i(nvm_addr_o), .wdata_i(nvm_wdata_o), .ack_o(nvm_ack_i),
        .rdata_o(nvm_rdata_i), .writes_o(writes), .faults_o(faults));

    task automatic results();
        if (errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Program results appear one edge after the strobe is taken and are checked a fixed two edges after it
    always @(posedge ref_clk_i) pv <= {pv[1:0], prog_valid_i & resetn_i};

    always @(negedge ref_clk_i) begin
        note_s n;
        if (reply_valid_o === 1'b1) begin
            if (rq.size() == 0) begin
                check("reply_valid_o", 32'h0, 32'h1);
            end else begin
                n = rq.pop_front();
                check("reply_status_o", n.st, reply_status_o);
                if (n.st == STATUS_OK) check("reply_cmd_o", n.cmd, reply_cmd_o);
                if (n.care) check("reply_value_o", n.val, reply_value_o);
                check("accu_o", n.acc, accu_o);
                check("xreg_o", n.xr, xreg_o);
            end
        end
        if (pv[2] && pq.size() > 0) begin
            n = pq.pop_front();
            check("accu_o", n.acc, accu_o);
            check("xreg_o", n.xr, xreg_o);
        end
    end

    task automatic tick();
        @(negedge ref_clk_i);
    endtask

    task automatic wait_idle();
        int i;
        for (i = 0; i < 400 && (busy_o !== 1'b0 || rq.size() > 0 || pq.size() > 0); i++) tick();
        if (i == 400) begin
            errors++;
            results();
        end
    endtask

    task automatic send(logic [7:0] cmd, logic [7:0] typ, logic [7:0] bank, logic [7:0] adr,
            logic bad);
        logic [7:0] b [9];
        b = '{adr, cmd, typ, bank, 8'h5A, 8'hC3, 8'h00, 8'h81, 8'h00};
        for (int i = 0; i < 8; i++) b[8] += b[i];
        b[8] = b[8] ^ {7'h0, bad};
        for (int i = 0; i < 9; i++) begin
            byte_valid_i = 1'b1;
            byte_i = b[i];
            tick();
        end
        byte_valid_i = 1'b0;
        repeat (5) tick();
        wait_idle();
    endtask

    task automatic host(logic [7:0] cmd, logic [7:0] typ, logic [7:0] bank, logic care,
            logic [31:0] val);
        wait_idle();
        rq.push_back('{STATUS_OK, cmd, care, val, acc, xr});
        send(cmd, typ, bank, 8'h01, 1'b0);
    endtask

    task automatic prog(logic [7:0] cmd, logic [7:0] typ);
        wait_idle();
        pq.push_back('{STATUS_OK, cmd, 1'b0, 32'h0, acc, xr});
        prog_cmd_i = cmd;
        prog_type_i = typ;
        prog_bank_i = 8'h00;
        prog_valid_i = 1'b1;
        tick();
        prog_valid_i = 1'b0;
        wait_idle();
    endtask

    // Bench shadow of the array and its nonvolatile copy
    task automatic store(int t, logic signed [31:0] v);
        ram[t] = v;
        if (persist_i && t != 0) begin
            rom[t] = v;
            wexp++;
        end
    endtask

    task automatic cap(int t);
        actual_pos_i = $urandom;
        store(t, actual_pos_i);
        host(CAPTURE_COORDINATE_CMD, 8'(t), 8'h00, 1'b0, 32'h0);
    endtask

    task automatic get_coordinate_cmd(int t);
        host(GET_COORDINATE_CMD, 8'(t), 8'h00, 1'b1, ram[t]);
    endtask

    task automatic pgco(int t);
        acc = ram[t];
        prog(GET_COORDINATE_CMD, 8'(t));
    endtask

    task automatic calc(logic [3:0] op);
        logic signed [31:0] t;
        t = acc;
        case (op)
            OP_ADD: acc = acc + xr;
            OP_SUB: acc = acc - xr;
            OP_MUL: acc = acc * xr;
            OP_DIV: acc = (xr == 0) ? 32'sh0 : acc / xr;
            OP_MOD: acc = (xr == 0) ? 32'sh0 : acc % xr;
            OP_AND: acc = acc & xr;
            OP_OR: acc = acc | xr;
            OP_XOR: acc = acc ^ xr;
            OP_NOT: xr = ~xr;
            OP_LOAD: xr = acc;
            default: begin
                acc = xr;
                xr = t;
            end
        endcase
    endtask

    initial begin
        void'($urandom(32'h3b4ce364));
        for (int i = 0; i <= 20; i++) begin
            ram[i] = 32'h0;
            rom[i] = 32'h0F000000 + i * 3;
        end
        acc = 32'h0;
        xr = 32'h0;
        repeat (8) tick();
        resetn_i = 1'b1;
        tick();
        foreach (ram[t]) if (t == 0 || t == 7 || t == 20) begin
            cap(t);
            get_coordinate_cmd(t);
            pgco(t);
        end
        calc(OP_LOAD);
        prog(XREG_CALCULATE_CMD, 8'(OP_LOAD));
        pgco(7);
        for (int op = 0; op <= 10; op++) begin
            calc(4'(op));
            if (op % 3 == 1) host(XREG_CALCULATE_CMD, 8'(op), 8'h00, 1'b0, 32'h0);
            else prog(XREG_CALCULATE_CMD, 8'(op));
        end
        store(3, acc);
        host(ACCU_TO_COORDINATE_CMD, 8'h03, 8'h00, 1'b0, 32'h0);
        get_coordinate_cmd(3);
        persist_i = 1'b1;
        cap(0);
        cap(12);
        store(20, acc);
        host(ACCU_TO_COORDINATE_CMD, 8'h14, 8'h00, 1'b0, 32'h0);
        persist_i = 1'b0;
        cap(12);
        cap(3);
        cap(5);
        ram[3] = rom[3];
        host(GET_COORDINATE_CMD, 8'h03, BANK_NVM, 1'b0, 32'h0);
        check("motor_sel_o", 32'h000000FF, {24'h0, motor_sel_o});
        get_coordinate_cmd(3);
        get_coordinate_cmd(12);
        for (int i = 1; i <= 20; i++) ram[i] = rom[i];
        host(GET_COORDINATE_CMD, 8'h00, BANK_NVM, 1'b0, 32'h0);
        foreach (ram[t]) if (t < 2 || t == 5 || t == 12 || t == 20) get_coordinate_cmd(t);
        cap(5);
        persist_i = 1'b1;
        resetn_i = 1'b0;
        repeat (2) tick();
        resetn_i = 1'b1;
        acc = 32'h0;
        xr = 32'h0;
        ram[5] = rom[5];
        get_coordinate_cmd(5);
        get_coordinate_cmd(0);
        persist_i = 1'b0;
        rq.push_back('{STATUS_BAD_CHECKSUM, 8'h00, 1'b0, 32'h0, acc, xr});
        send(GET_COORDINATE_CMD, 8'h01, 8'h00, 8'h01, 1'b1);
        send(GET_COORDINATE_CMD, 8'h01, 8'h00, 8'h02, 1'b0);
        check("nvm writes", wexp, writes);
        check("nvm faults", 32'h0, faults);
        results();
    end
endmodule
